// ===== rtl/ext_bus_pkg.sv
package ext_bus_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [1:0] WAIT_RESET = 2'h0;
   localparam logic [1:0] SYNC_RESET = 2'h3;

   typedef enum logic [1:0] {
      SPACE_DATA,
      SPACE_PROG,
      SPACE_IO,
      SPACE_GLOBAL
   } space_t;

   // Core request to the external bus
   typedef struct packed {
      space_t            space;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

   // Single-access RAM port, used by the outside master during DMA
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ram_req_t;

   // Pin inputs, for the raw sample and both synchroniser stages
   typedef struct packed {
      logic              hold_n;
      logic              ready;
      logic              off_n;
      logic              busReqIn_n;
      logic              strobeIn_n;
      logic              rwIn;
      logic [ADDR_W-1:0] addrIn;
      logic [DATA_W-1:0] dataIn;
   } pins_in_t;
endpackage

// ===== rtl/ext_bus_fifo.sv
module ext_bus_fifo
   import ext_bus_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wrPtr;
      logic [AW-1:0]               rdPtr;
      logic [AW:0]                 count;
   } fifo_state_t;

   fifo_state_t state;
   fifo_state_t next_state;
   logic        doPush;
   logic        doPop;

   // Honest flags straight from the count
   assign inReady  = (state.count != (AW+1)'(DEPTH));
   assign outValid = (state.count != '0);
   assign outData  = state.mem[state.rdPtr];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   // Pointer and occupancy update
   always_comb begin
      next_state = state;
      if (doPush) begin
         next_state.mem[state.wrPtr] = inData;
         next_state.wrPtr = state.wrPtr + AW'(1);
      end
      if (doPop) begin
         next_state.rdPtr = state.rdPtr + AW'(1);
      end
      case ({doPush, doPop})
         2'b10:   next_state.count = state.count + (AW+1)'(1);
         2'b01:   next_state.count = state.count - (AW+1)'(1);
         default: next_state.count = state.count;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule

// ===== rtl/ext_bus_port.sv
module ext_bus_port
   import ext_bus_pkg::*;
#(
   parameter int FIFO_W = ADDR_W + DATA_W + 3,
   parameter int DEPTH  = FIFO_DEPTH
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              device_reset_n,
   // Core side request stream
   input  wire logic              reqValid,
   output logic                   reqReady,
   input  wire bus_req_t          req,
   output logic                   rdValid,
   output logic      [DATA_W-1:0] rdData,
   // On-chip single-access RAM port
   output logic                   ramValid,
   output ram_req_t               ramReq,
   input  wire logic [DATA_W-1:0] ramRdata,
   // Pins
   input  wire logic              hold_n,
   input  wire logic              ready,
   input  wire logic              float_all_n,
   output logic      [ADDR_W-1:0] addrOut,
   output logic                   addrOe,
   input  wire logic [ADDR_W-1:0] addrIn,
   output logic      [DATA_W-1:0] dataOut,
   output logic                   dataOe,
   input  wire logic [DATA_W-1:0] dataIn,
   output logic                   data_space_select_n,
   output logic                   program_space_select_n,
   output logic                   io_space_select_n,
   output logic                   ctrlOe,
   output logic                   readWriteOut,
   input  wire logic              readWriteIn,
   output logic                   bus_cycle_strobe_nOut,
   input  wire logic              bus_cycle_strobe_nIn,
   output logic                   read_select_n,
   output logic                   write_select_n,
   output logic                   hold_acknowledge_n,
   output logic                   global_bus_request_nOut,
   output logic                   globalBusReqOe,
   input  wire logic              global_bus_request_nIn,
   output logic                   acquisition_ack_n,
   output logic                   ackOe
);
   typedef enum logic [2:0] {
      IDLE,
      ARBITRATE,
      ACCESS,
      WRITE_END,
      HOLD,
      DMA
   } phase_t;

   typedef struct packed {
      pins_in_t          sync1;
      pins_in_t          sync2;
      logic              resetSync1;
      logic              resetSync2;
      phase_t            phase;
      // Synced ready lags two edges, so a fresh cycle ignores it until bit 1 is set
      logic [1:0]        fresh;
      bus_req_t          cur;
      logic              dmaStrobeLast;
      logic [ADDR_W-1:0] addrOut;
      logic [DATA_W-1:0] dataOut;
      logic              addrOe;
      logic              dataOe;
      logic              ctrlOe;
      logic              dsN;
      logic              psN;
      logic              isN;
      logic              rwOut;
      logic              strobeN;
      logic              rdN;
      logic              wrN;
      logic              holdAckN;
      logic              gbrN;
      logic              gbrOe;
      logic              acqN;
      logic              ackOe;
      logic              rdValid;
      logic [DATA_W-1:0] rdData;
      logic              ramValid;
      ram_req_t          ramReq;
      logic              dmaRead;
   } port_state_t;

   port_state_t state;
   port_state_t next_state;
   pins_in_t    pinsNow;
   logic        qValid;
   logic        qPop;
   bus_req_t    qReq;

   // Select line for one space, low only for its match
   function automatic logic spaceSel(input space_t have, input space_t want);
      return !(have == want);
   endfunction

   assign pinsNow = '{hold_n: hold_n, ready: ready, off_n: float_all_n,
                      busReqIn_n: global_bus_request_nIn, strobeIn_n: bus_cycle_strobe_nIn,
                      rwIn: readWriteIn, addrIn: addrIn, dataIn: dataIn};

   // Buffer between the core and the pins; back-pressure reaches reqReady
   ext_bus_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) reqFifo (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .inValid  (reqValid),
      .inReady  (reqReady),
      .inData   (FIFO_W'(req)),
      .outValid (qValid),
      .outReady (qPop),
      .outData  (qReq)
   );

   assign qPop = (state.phase == IDLE) && qValid && state.sync2.hold_n && state.resetSync2;

   always_comb begin
      next_state = state;
      next_state.sync1 = pinsNow;
      next_state.sync2 = state.sync1;
      next_state.resetSync1 = device_reset_n;
      next_state.resetSync2 = state.resetSync1;
      next_state.rdValid = 1'b0;
      next_state.ramValid = 1'b0;
      next_state.dmaStrobeLast = state.sync2.strobeIn_n;
      case (state.phase)
         IDLE: begin
            next_state.dataOe = 1'b0;
            next_state.addrOe = 1'b1;
            next_state.ctrlOe = 1'b1;
            next_state.holdAckN = 1'b1;
            // Request line driven again once float-all has lifted
            next_state.gbrOe = 1'b1;
            if (!state.sync2.hold_n) begin
               next_state.phase = HOLD;
            end else if (qPop) begin
               next_state.cur = qReq;
               next_state.fresh = WAIT_RESET;
               // every space shares the one address bus
               next_state.addrOut = qReq.addr;
               if (qReq.space == SPACE_GLOBAL) begin
                  // global access waits for a grant
                  next_state.gbrN = 1'b0;
                  next_state.dsN = 1'b0;
                  next_state.phase = ARBITRATE;
               end else begin
                  // one select low for the matching space
                  next_state.dsN = spaceSel(qReq.space, SPACE_DATA);
                  next_state.psN = spaceSel(qReq.space, SPACE_PROG);
                  next_state.isN = spaceSel(qReq.space, SPACE_IO);
                  next_state.phase = ACCESS;
               end
               // strobe low for the bus cycle only
               next_state.strobeN = 1'b0;
               next_state.rwOut = !qReq.write;
               next_state.rdN = qReq.write;
               // write select low with data driven
               next_state.wrN = !qReq.write;
               next_state.dataOut = qReq.wdata;
               // data bus driven only for write data
               next_state.dataOe = qReq.write;
            end
         end
         ARBITRATE: begin
            // Stale ready from the last cycle must not count as a grant
            next_state.fresh = {state.fresh[0], 1'b1};
            if (state.fresh[1] && state.sync2.ready) begin
               next_state.phase = ACCESS;
            end
         end
         ACCESS: begin
            // Back-to-back cycles would otherwise end on the previous ready
            next_state.fresh = {state.fresh[0], 1'b1};
            // ready low inserts a wait and is sampled again
            if (state.fresh[1] && state.sync2.ready) begin
               next_state.strobeN = 1'b1;
               next_state.rdN = 1'b1;
               next_state.wrN = 1'b1;
               next_state.dsN = 1'b1;
               next_state.psN = 1'b1;
               next_state.isN = 1'b1;
               next_state.gbrN = 1'b1;
               next_state.rdValid = !state.cur.write;
               next_state.rdData = state.sync2.dataIn;
               // Data held one cycle past write select rise
               next_state.phase = state.cur.write ? WRITE_END : IDLE;
            end
         end
         WRITE_END: begin
            next_state.rwOut = 1'b1;
            next_state.dataOe = 1'b0;
            next_state.phase = IDLE;
         end
         HOLD: begin
            // address and controls float in hold
            next_state.addrOe = 1'b0;
            next_state.ctrlOe = 1'b0;
            next_state.dataOe = 1'b0;
            next_state.gbrOe = 1'b0;
            next_state.holdAckN = 1'b0;
            next_state.acqN = 1'b1;
            if (state.sync2.hold_n) begin
               next_state.phase = IDLE;
               next_state.gbrOe = 1'b1;
            end else if (!state.holdAckN && !state.sync2.busReqIn_n) begin
               // grant the RAM by acknowledge low
               next_state.acqN = 1'b0;
               next_state.phase = DMA;
            end
         end
         DMA: begin
            next_state.dataOe = 1'b0;
            if (state.sync2.hold_n || state.sync2.busReqIn_n) begin
               next_state.acqN = 1'b1;
               next_state.phase = HOLD;
            end else if (!state.sync2.strobeIn_n && state.dmaStrobeLast) begin
               // address pins feed the RAM; strobe edge qualifies it
               next_state.ramValid = 1'b1;
               next_state.ramReq = '{write: !state.sync2.rwIn, addr: state.sync2.addrIn,
                                     wdata: state.sync2.dataIn};
               next_state.dmaRead = state.sync2.rwIn;
            end else if (state.sync2.strobeIn_n) begin
               next_state.dmaRead = 1'b0;
            end
            // RAM read data driven while strobe qualifies a read
            if (state.dmaRead && !state.sync2.strobeIn_n) begin
               next_state.dataOut = ramRdata;
               next_state.dataOe = 1'b1;
            end
         end
         default: next_state.phase = IDLE;
      endcase
      // float-all overrides every drive; reset overrides only the data drive
      if (!state.sync2.off_n || !state.resetSync2) begin
         next_state.dataOe = 1'b0;
         if (!state.sync2.off_n) begin
            next_state.addrOe = 1'b0;
            next_state.ctrlOe = 1'b0;
            next_state.gbrOe = 1'b0;
         end
      end
      // Pins that belong to the pair of DMA roles
      next_state.ackOe = state.sync2.off_n;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= '{sync1: '1, sync2: '1, resetSync1: 1'b0, resetSync2: 1'b0, phase: IDLE,
                    cur: '0, fresh: WAIT_RESET, dmaStrobeLast: 1'b1, addrOut: ADDR_RESET, dataOut: DATA_RESET,
                    addrOe: 1'b1, dataOe: 1'b0, ctrlOe: 1'b1, dsN: 1'b1, psN: 1'b1, isN: 1'b1,
                    rwOut: 1'b1, strobeN: 1'b1, rdN: 1'b1, wrN: 1'b1, holdAckN: 1'b1,
                    gbrN: 1'b1, gbrOe: 1'b1, acqN: 1'b1, ackOe: 1'b1, rdValid: 1'b0,
                    rdData: DATA_RESET, ramValid: 1'b0, ramReq: '0, dmaRead: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   // All pins straight from the state flops
   assign addrOut                 = state.addrOut;
   assign addrOe                  = state.addrOe;
   assign dataOut                 = state.dataOut;
   assign dataOe                  = state.dataOe;
   assign data_space_select_n     = state.dsN;
   assign program_space_select_n  = state.psN;
   assign io_space_select_n       = state.isN;
   assign ctrlOe                  = state.ctrlOe;
   assign readWriteOut            = state.rwOut;
   assign bus_cycle_strobe_nOut   = state.strobeN;
   assign read_select_n           = state.rdN;
   assign write_select_n          = state.wrN;
   assign hold_acknowledge_n      = state.holdAckN;
   assign global_bus_request_nOut = state.gbrN;
   assign globalBusReqOe          = state.gbrOe;
   assign acquisition_ack_n       = state.acqN;
   assign ackOe                   = state.ackOe;
   assign rdValid                 = state.rdValid;
   assign rdData                  = state.rdData;
   assign ramValid                = state.ramValid;
   assign ramReq                  = state.ramReq;
endmodule

// ===== verification/ext_bus_port_checker.sv
module ext_bus_port_checker
   import ext_bus_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic device_reset_n,
   input wire logic ready,
   input wire logic float_all_n,
   input wire logic addrOe,
   input wire logic dataOe,
   input wire logic ctrlOe,
   input wire logic readWriteOut,
   input wire logic bus_cycle_strobe_nOut,
   input wire logic data_space_select_n,
   input wire logic program_space_select_n,
   input wire logic io_space_select_n,
   input wire logic read_select_n,
   input wire logic write_select_n,
   input wire logic hold_acknowledge_n,
   input wire logic acquisition_ack_n,
   input wire logic ackOe
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, all checks quiet in reset
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   chk_one_space: assert property (
      ctrlOe |-> $countones({data_space_select_n, program_space_select_n, io_space_select_n}) >= 2)
      else $error("more than one space select low");
   chk_write_dir: assert property (
      !write_select_n |-> !readWriteOut)
      else $error("write select without write direction");
   chk_read_qual: assert property (
      !read_select_n |-> readWriteOut && !bus_cycle_strobe_nOut)
      else $error("read select outside a read cycle");
   chk_hold_float: assert property (
      !hold_acknowledge_n |-> !addrOe && !ctrlOe)
      else $error("pins driven in hold");
   chk_float_all: assert property (
      !float_all_n [*4] |-> !addrOe && !dataOe && !ctrlOe && !ackOe)
      else $error("pins driven under float-all");
   chk_reset_float: assert property (
      !device_reset_n [*4] |-> !dataOe)
      else $error("data driven in pin reset");
   chk_data_write: assert property (
      dataOe && hold_acknowledge_n |-> !readWriteOut)
      else $error("data driven outside a write");
   chk_acq_hold: assert property (
      !acquisition_ack_n |-> !hold_acknowledge_n)
      else $error("acquisition ack without hold");
   chk_wait_ready: assert property (
      !ready [*5] ##0 !bus_cycle_strobe_nOut |=> !bus_cycle_strobe_nOut)
      else $error("cycle ended while not ready");
   chk_ready_ends: assert property (
      ready [*3] ##0 !bus_cycle_strobe_nOut |-> ##[1:8] bus_cycle_strobe_nOut)
      else $error("cycle not ended after ready");
endmodule

bind ext_bus_port ext_bus_port_checker #(.DEPTH(DEPTH)) checker_inst (
   .mclk, .rst_n, .device_reset_n, .ready, .float_all_n, .addrOe, .dataOe, .ctrlOe, .readWriteOut,
   .bus_cycle_strobe_nOut, .data_space_select_n, .program_space_select_n, .io_space_select_n,
   .read_select_n, .write_select_n, .hold_acknowledge_n, .acquisition_ack_n, .ackOe
);

// ===== verification/ext_mem_model.sv
module ext_mem_model
   import ext_bus_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic [3:0]        waitCycles,
   input  wire logic              strobe_n,
   input  wire logic              busReq_n,
   input  wire logic              readSel_n,
   input  wire logic              writeSel_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   output logic                   ready,
   output logic      [DATA_W-1:0] rdata,
   output logic                   rdataOe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [256];
   logic [DATA_W-1:0] held;
   logic [3:0]        waited;

   // Predictable preload so reads can be checked
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'h3c00 | DATA_W'(i);
      end
   end

   // slow or prompt ready, doubling as the global grant
   always @(negedge mclk) begin
      if (strobe_n && busReq_n) begin
         ready <= 1'b0;
         waited <= 4'h0;
      end else if (waited >= waitCycles) begin
         ready <= 1'b1;
      end else begin
         waited <= waited + 4'h1;
      end
   end

   // write data taken on the rising edge of write select
   always @(posedge writeSel_n) begin
      mem[addr[7:0]] <= wdata;
   end

   // drive only while read select is low, else a toggling pattern
   assign rdataOe = !readSel_n;
   assign rdata   = rdataOe ? mem[addr[7:0]] : ~held;
   always @(negedge mclk) begin
      held <= rdata;
   end
endmodule

// ===== verification/test_external_bus_and_dma_port.sv
module test_external_bus_and_dma_port
   import ext_bus_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk, rst_n, device_reset_n, reqValid, reqReady, rdValid, ramValid, hold_n, ready;
   logic              float_all_n, addrOe, dataOe, ctrlOe, readWriteOut, readWriteIn, ackOe, acquisition_ack_n;
   logic              data_space_select_n, program_space_select_n, io_space_select_n, read_select_n;
   logic              bus_cycle_strobe_nOut, bus_cycle_strobe_nIn, write_select_n, hold_acknowledge_n;
   logic              global_bus_request_nOut, globalBusReqOe, global_bus_request_nIn;
   logic              memOe, dmaOe, dmaRw, dmaStb_n, dmaBr_n;
   logic [DATA_W-1:0] rdData, ramRdata, dataOut, dataIn, memData, dmaData;
   logic [ADDR_W-1:0] addrOut, addrIn, dmaAddr;
   logic [3:0]        waitCycles;
   bus_req_t          req;
   ram_req_t          ramReq;
   int                failures, cmp_count;

   // Shared pins resolved from every enable; undriven lines do not keep a value
   assign addrIn = addrOe ? addrOut : acquisition_ack_n ? ~addrOut : dmaAddr;
   assign dataIn = dataOe ? dataOut : memOe ? memData : dmaOe ? dmaData : ~dataOut;
   assign readWriteIn = ctrlOe ? readWriteOut : dmaRw;
   assign bus_cycle_strobe_nIn = ctrlOe ? bus_cycle_strobe_nOut : dmaStb_n;
   assign global_bus_request_nIn = globalBusReqOe ? global_bus_request_nOut : dmaBr_n;
   assign ramRdata = ramReq.addr ^ 16'h5a5a;

   ext_bus_port #(.DEPTH(FIFO_DEPTH)) dut (
      .mclk, .rst_n, .device_reset_n, .reqValid, .reqReady, .req, .rdValid, .rdData, .ramValid, .ramReq,
      .ramRdata, .hold_n, .ready, .float_all_n, .addrOut, .addrOe, .addrIn, .dataOut, .dataOe, .dataIn,
      .data_space_select_n, .program_space_select_n, .io_space_select_n, .ctrlOe, .readWriteOut, .readWriteIn,
      .bus_cycle_strobe_nOut, .bus_cycle_strobe_nIn, .read_select_n, .write_select_n, .hold_acknowledge_n,
      .global_bus_request_nOut, .globalBusReqOe, .global_bus_request_nIn, .acquisition_ack_n, .ackOe
   );
   ext_mem_model memModel (
      .mclk, .waitCycles, .strobe_n(bus_cycle_strobe_nIn), .busReq_n(global_bus_request_nIn),
      .readSel_n(ctrlOe ? read_select_n : 1'b1), .writeSel_n(ctrlOe ? write_select_n : 1'b1),
      .addr(addrIn), .wdata(dataIn), .ready, .rdata(memData), .rdataOe(memOe)
   );

   // Free-running core clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic timeout();
      failures++;
      stop_test();
   endtask

   function automatic logic [2:0] sel(input space_t sp);
      return sp == SPACE_PROG ? 3'b101 : sp == SPACE_IO ? 3'b110 : 3'b011;
   endfunction

   // Bounded wait for hold or acquisition acknowledge to reach a level
   task automatic wait_ack(input logic acq, input logic v);
      int n;
      for (n = 0; n < 50 && (acq ? acquisition_ack_n : hold_acknowledge_n) !== v; n++) @(negedge mclk);
      if (n == 50) timeout();
   endtask

   // One core access; d is the write data or the expected read data
   task automatic access(input space_t sp, input logic wr, input logic [15:0] a, input logic [15:0] d,
                         output int len);
      int n;
      logic [21:0] pins;
      @(negedge mclk);
      req = '{sp, wr, a, d};
      reqValid = 1'b1;
      @(negedge mclk);
      reqValid = 1'b0;
      len = 0;
      for (n = 0; n < 80 && !(len > 0 && bus_cycle_strobe_nOut && readWriteOut); n++) begin
         pins = {addrOut, data_space_select_n, program_space_select_n, io_space_select_n, readWriteOut,
                 read_select_n, global_bus_request_nOut};
         if (!bus_cycle_strobe_nOut) begin
            if (len == 0) check(pins, {a, sel(sp), !wr, wr, sp != SPACE_GLOBAL});
            len++;
         end
         if (!write_select_n) check({dataOe, dataOut}, {1'b1, d});
         @(negedge mclk);
      end
      if (n == 80) timeout();
      if (!wr) check({rdValid, rdData}, {1'b1, d});
   endtask

   task automatic t_reset();
      check({data_space_select_n, program_space_select_n, io_space_select_n, bus_cycle_strobe_nOut}, 4'hf);
      check({readWriteOut, read_select_n, write_select_n, hold_acknowledge_n, acquisition_ack_n, dataOe}, 6'h3e);
      $display("test reset done");
   endtask

   task automatic t_spaces();
      int len;
      for (int k = 0; k < 4; k++) begin
         access(space_t'(k), 1'b1, 16'h0010 + 16'(k), 16'hd000 + 16'(k), len);
         access(space_t'(k), 1'b0, 16'h0010 + 16'(k), 16'hd000 + 16'(k), len);
      end
      access(SPACE_DATA, 1'b0, 16'h0020, 16'h3c20, len);
      $display("test spaces done");
   endtask

   task automatic t_wait();
      int len0, len3;
      access(SPACE_DATA, 1'b0, 16'h0030, 16'h3c30, len0);
      waitCycles = 4'h3;
      access(SPACE_IO, 1'b0, 16'h0031, 16'h3c31, len3);
      waitCycles = 4'h0;
      check(48'(len3 - len0), 48'd3);
      $display("test wait done");
   endtask

   // FIFO filled while held off the bus, then drained against a slow memory
   task automatic t_fill();
      int n, idx;
      hold_n = 1'b0;
      wait_ack(1'b0, 1'b0);
      check({addrOe, ctrlOe, dataOe, hold_acknowledge_n}, 4'h0);
      req = '{SPACE_DATA, 1'b0, 16'h0040, 16'h0000};
      reqValid = 1'b1;
      for (n = 0; n < 40 && reqReady === 1'b1; n++) begin
         req.addr = 16'h0040 + 16'(n);
         @(negedge mclk);
      end
      reqValid = 1'b0;
      check(48'(n), 48'(FIFO_DEPTH));
      waitCycles = 4'h2;
      hold_n = 1'b1;
      idx = 0;
      for (n = 0; n < 800 && idx < FIFO_DEPTH; n++) begin
         @(negedge mclk);
         if (rdValid === 1'b1) begin
            check(rdData, 16'h3c40 + 16'(idx));
            idx++;
         end
      end
      if (idx < FIFO_DEPTH) timeout();
      waitCycles = 4'h0;
      $display("test fill done");
   endtask

   // Outside master writes then reads the on-chip RAM under hold
   task automatic t_dma();
      int hits;
      hold_n = 1'b0;
      wait_ack(1'b0, 1'b0);
      dmaBr_n = 1'b0;
      wait_ack(1'b1, 1'b0);
      for (int k = 0; k < 2; k++) begin
         // direction, address, data and strobe from the outside master
         dmaRw = k[0];
         dmaAddr = 16'h0055 + 16'(k);
         dmaData = 16'hbeef;
         dmaOe = !k[0];
         dmaStb_n = 1'b0;
         hits = 0;
         repeat (6) begin
            @(negedge mclk);
            if (ramValid === 1'b1) hits++;
         end
         check({hits[3:0], ramReq.write, ramReq.addr}, {4'h1, !k[0], dmaAddr});
         if (k == 0) check(ramReq.wdata, 16'hbeef);
         else check({dataOe, dataOut}, {1'b1, dmaAddr ^ 16'h5a5a});
         dmaStb_n = 1'b1;
         dmaOe = 1'b0;
         repeat (3) @(negedge mclk);
      end
      dmaBr_n = 1'b1;
      wait_ack(1'b1, 1'b1);
      hold_n = 1'b1;
      wait_ack(1'b0, 1'b1);
      $display("test dma done");
   endtask

   task automatic t_float();
      float_all_n = 1'b0;
      device_reset_n = 1'b0;
      repeat (5) @(negedge mclk);
      check({addrOe, dataOe, ctrlOe, ackOe, globalBusReqOe}, 5'h00);
      float_all_n = 1'b1;
      device_reset_n = 1'b1;
      repeat (5) @(negedge mclk);
      check({addrOe, ctrlOe, dataOe, ackOe, globalBusReqOe}, 5'b11011);
      $display("test float done");
   endtask

   // Main sequence, inputs changed only at falling edges
   initial begin
      {rst_n, device_reset_n, reqValid, hold_n, float_all_n, dmaOe, dmaRw, dmaStb_n, dmaBr_n} = 9'b010110111;
      req = '0;
      dmaAddr = 16'h0000;
      dmaData = 16'h0000;
      waitCycles = 4'h0;
      failures = 0;
      cmp_count = 0;
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_reset();
      t_spaces();
      t_wait();
      t_fill();
      t_dma();
      t_float();
      stop_test();
   end
endmodule
